// File: shared/pfm_pkg.sv
package pfm_pkg;

  // ==========================================================
  // register port
  localparam int unsigned ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFS_PIN_LEVEL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_OUT_LATCH = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_DIRECTION = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_ANALOG_ENABLE_BIT_LOW = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_ANALOG_ENABLE_BIT_HIGH = 4'h4;

  // ==========================================================
  // reset values and masks
  localparam logic [7:0] IMPL_MASK = 8'hfe;
  localparam logic [7:0] LATCH_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'hfe;
  localparam logic [15:0] ANALOG_ENABLE_BIT_RST = 16'hffff;
  localparam logic [7:0] RDATA_RST = 8'h00;

  // ==========================================================
  // pin positions of shared functions
  localparam int unsigned PIN_CMP2 = 1;
  localparam int unsigned PIN_CMP1 = 2;
  localparam int unsigned PIN_CHARGER = 3;
  localparam int unsigned PIN_VREF = 5;
  localparam int unsigned PIN_SSEL = 7;
  localparam int unsigned PIN_PDLY = 1;

  // analog channel carried by each pin, index 0 unused
  localparam logic [3:0] PIN_CHAN [8] = '{
    4'h0, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'h5
  };

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pfm_bus_req_s;

  typedef struct packed {
    logic cmp_one_result;
    logic cmp_one_out_en;
    logic cmp_two_result;
    logic cmp_two_out_en;
    logic vref_out_en;
    logic charger_en;
  } pfm_cmp_s;

  // ==========================================================
  // per-pin analog mode from the channel select bits
  function automatic logic [7:0] pfm_analog_mask(input logic [15:0] analog_enable_bit);
    logic [7:0] m;
    m = 8'h00;
    for (int p = 1; p < 8; p++) begin
      m[p] = analog_enable_bit[PIN_CHAN[p]];
    end
    return m;
  endfunction

endpackage

// File: sim/pfm_port_f_pin_mux_monitor.sv
`timescale 1ns/1ps
module pfm_port_f_pin_mux_monitor
  import pfm_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire pfm_bus_req_s i_bus,
  input wire logic [7:0] o_rdata,
  input wire logic [7:0] i_pin_st,
  input wire logic i_pin7_ttl,
  input wire logic [7:0] o_pin_out,
  input wire logic [7:0] o_pin_oe,
  input wire pfm_cmp_s i_cmp,
  input wire logic [7:0] o_analog_sel,
  input wire logic o_pulse_delay_input,
  input wire logic o_serial_slave_select,
  input wire logic o_charger_current_output
);
  // ==========
  // checks
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  bit_zero_a: assert property (!o_pin_out[0] && !o_pin_oe[0])
    else $error("bit0");
  reset_mode_a: assert property (!$past(i_nrst) |-> o_analog_sel == 8'hfe)
    else $error("reset");
  vref_off_a: assert property ($past(i_cmp.vref_out_en) |->
    !o_pin_oe[5] && !o_pin_out[5])
    else $error("vref");
  charger_on_a: assert property ($past(i_nrst) |->
    o_charger_current_output == $past(i_cmp.charger_en))
    else $error("charger");
  cmp_two_a: assert property ($past(i_nrst) && $past(i_cmp.cmp_two_out_en) && o_pin_oe[1]
    |-> o_pin_out[1] == $past(i_cmp.cmp_two_result))
    else $error("cmp2");
  cmp_one_a: assert property ($past(i_nrst) && $past(i_cmp.cmp_one_out_en) && o_pin_oe[2]
    |-> o_pin_out[2] == $past(i_cmp.cmp_one_result))
    else $error("cmp1");
  pdly_route_a: assert property ($past(i_nrst) && !o_pin_oe[1]
    |-> o_pulse_delay_input == $past(i_pin_st[1]))
    else $error("pdly");
  ssel_route_a: assert property ($past(i_nrst) && !o_pin_oe[7]
    |-> o_serial_slave_select == $past(i_pin7_ttl))
    else $error("ssel");
  ssel_idle_a: assert property (o_pin_oe[7] |-> o_serial_slave_select)
    else $error("ssel idle");
endmodule
bind pfm_port_f_pin_mux pfm_port_f_pin_mux_monitor u_mon (.*);

// File: sim/tb_pfm_port_f_pin_mux.sv
`timescale 1ns/1ps
module tb_pfm_port_f_pin_mux
  import pfm_pkg::*;
;
  logic i_mclk = 1'b0;
  logic i_nrst = 1'b0;
  pfm_bus_req_s i_bus = '0;
  logic [7:0] i_pin_st = 8'hff;
  logic i_pin7_ttl = 1'b1;
  pfm_cmp_s i_cmp = '0;
  logic [7:0] o_rdata, o_pin_out, o_pin_oe, o_analog_sel;
  logic o_pulse_delay_input, o_serial_slave_select, o_charger_current_output;
  int fail_count = 0;
  int check_count = 0;
  int cyc = 0;
  int ch [7] = '{6, 7, 8, 9, 10, 11, 5};
  logic [15:0] m;
  always #20 i_mclk = ~i_mclk;
  pfm_port_f_pin_mux dut (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_bus(i_bus),
    .o_rdata(o_rdata),
    .i_pin_st(i_pin_st),
    .i_pin7_ttl(i_pin7_ttl),
    .o_pin_out(o_pin_out),
    .o_pin_oe(o_pin_oe),
    .i_cmp(i_cmp),
    .o_analog_sel(o_analog_sel),
    .o_pulse_delay_input(o_pulse_delay_input),
    .o_serial_slave_select(o_serial_slave_select),
    .o_charger_current_output(o_charger_current_output)
  );
  // ==========
  // tasks
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %0t got %h want %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_bus <= '{a, d, 1'b1, 1'b0};
    @(posedge i_mclk);
    i_bus <= '0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    @(posedge i_mclk);
    i_bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge i_mclk);
    i_bus <= '0;
    #1 chk(o_rdata, e);
  endtask
  task automatic st;
    repeat (2) @(posedge i_mclk);
    #1;
  endtask
  task automatic drv(input pfm_cmp_s c, input logic [7:0] p, input logic t);
    @(posedge i_mclk);
    i_cmp <= c;
    i_pin_st <= p;
    i_pin7_ttl <= t;
    st;
  endtask
  task automatic conclude;
    if (fail_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc > 2000) begin
      fail_count++;
      conclude;
    end
  end
  // ==========
  // tests
  initial begin
    repeat (4) @(posedge i_mclk);
    i_nrst <= 1'b1;
    rd(OFS_OUT_LATCH, 8'h00);
    rd(OFS_DIRECTION, 8'hfe);
    rd(OFS_ANALOG_ENABLE_BIT_LOW, 8'hff);
    rd(OFS_ANALOG_ENABLE_BIT_HIGH, 8'hff);
    rd(OFS_PIN_LEVEL, 8'h00);
    rd(4'hf, 8'h00);
    chk(o_analog_sel, 8'hfe);
    for (int p = 1; p < 8; p++) begin
      m = 16'h1 << ch[p-1];
      wr(OFS_ANALOG_ENABLE_BIT_LOW, m[7:0]);
      wr(OFS_ANALOG_ENABLE_BIT_HIGH, m[15:8]);
      st;
      chk(o_analog_sel, 8'h1 << p);
    end
    wr(OFS_OUT_LATCH, 8'hff);
    wr(OFS_DIRECTION, 8'h01);
    rd(OFS_OUT_LATCH, 8'hfe);
    rd(OFS_DIRECTION, 8'h00);
    st;
    chk(o_pin_out, 8'hfe);
    chk(o_pin_oe, 8'hfe);
    drv(6'b010100, 8'hff, 1'b1);
    chk(o_pin_out, 8'hf8);
    drv(6'b011111, 8'hff, 1'b1);
    chk(o_pin_out, 8'hda);
    chk(o_pin_oe, 8'hde);
    chk(o_charger_current_output, 1'b1);
    drv(6'b000000, 8'ha5, 1'b0);
    chk(o_charger_current_output, 1'b0);
    wr(OFS_DIRECTION, 8'hff);
    wr(OFS_ANALOG_ENABLE_BIT_LOW, 8'h00);
    wr(OFS_ANALOG_ENABLE_BIT_HIGH, 8'h00);
    rd(OFS_PIN_LEVEL, 8'ha4);
    st;
    chk(o_serial_slave_select, 1'b0);
    chk(o_pulse_delay_input, 1'b0);
    drv(6'b000001, 8'h02, 1'b1);
    chk(o_pulse_delay_input, 1'b1);
    chk(o_charger_current_output, 1'b1);
    chk(o_serial_slave_select, 1'b1);
    drv(6'b000010, 8'hff, 1'b1);
    wr(OFS_ANALOG_ENABLE_BIT_LOW, 8'he0);
    rd(OFS_PIN_LEVEL, 8'h58);
    wr(OFS_DIRECTION, 8'h00);
    drv(6'b000000, 8'hff, 1'b0);
    chk(o_serial_slave_select, 1'b1);
    chk(o_pulse_delay_input, 1'b0);
    @(posedge i_mclk);
    i_nrst <= 1'b0;
    @(posedge i_mclk);
    i_nrst <= 1'b1;
    rd(OFS_DIRECTION, 8'hfe);
    rd(OFS_ANALOG_ENABLE_BIT_HIGH, 8'hff);
    chk(o_analog_sel, 8'hfe);
    chk(o_pin_oe, 8'h00);
    conclude;
  end
endmodule

// File: src/pfm_pin_drive.sv
`timescale 1ns/1ps
module pfm_pin_drive
  import pfm_pkg::*;
(
  input wire logic [7:0] i_latch,
  input wire logic [7:0] i_dir,
  input wire pfm_cmp_s i_cmp,
  output logic [7:0] o_out,
  output logic [7:0] o_oe
);

  // ==========================================================
  // output value and enable per pin
  always_comb begin
    o_out = i_latch & IMPL_MASK;
    o_oe = ~i_dir & IMPL_MASK;
    if (i_cmp.cmp_two_out_en) begin
      o_out[PIN_CMP2] = i_cmp.cmp_two_result;
    end
    if (i_cmp.cmp_one_out_en) begin
      o_out[PIN_CMP1] = i_cmp.cmp_one_result;
    end
    if (i_cmp.vref_out_en) begin
      o_oe[PIN_VREF] = 1'b0;
      o_out[PIN_VREF] = 1'b0;
    end
  end

endmodule

// File: src/pfm_pin_sense.sv
`timescale 1ns/1ps
module pfm_pin_sense
  import pfm_pkg::*;
(
  input wire logic [7:0] i_pin_st,
  input wire logic [7:0] i_dir,
  input wire logic [15:0] i_analog_enable_bit,
  input wire logic i_vref_out_en,
  output logic [7:0] o_level,
  output logic o_pdly
);

  logic [7:0] dig_en;

  // ==========================================================
  // digital input path
  always_comb begin
    dig_en = ~pfm_analog_mask(i_analog_enable_bit) & IMPL_MASK;
    if (i_vref_out_en) begin
      dig_en[PIN_VREF] = 1'b0;
    end
    o_level = i_pin_st & dig_en;
    o_pdly = i_dir[PIN_PDLY] & i_pin_st[PIN_PDLY];
  end

endmodule

// File: src/pfm_port_f_pin_mux.sv
`timescale 1ns/1ps
// How it works
// - direction 0 drives the pin from its latch bit, analog or not
// - direction 1 reads the Schmitt level; analog mode disables it
// - after reset pins 1 to 7 have their converter channel selected
// - enabled comparator result replaces latch on pins 1 and 2
// - reference output on pin 5 disables its driver and input
// - pin 1 input goes to the pulse-delay input when direction 1
// - pin 7 TTL input goes to the serial slave select when direction 1
// - bit 0 of level, latch and direction is absent and reads 0
// - charger output on pin 3 ignores the direction bit
// - after reset pins 1 to 7 are analog and read 0
module pfm_port_f_pin_mux
  import pfm_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire pfm_bus_req_s i_bus,
  output logic [7:0] o_rdata,
  input wire logic [7:0] i_pin_st,
  input wire logic i_pin7_ttl,
  output logic [7:0] o_pin_out,
  output logic [7:0] o_pin_oe,
  input wire pfm_cmp_s i_cmp,
  output logic [7:0] o_analog_sel,
  output logic o_pulse_delay_input,
  output logic o_serial_slave_select,
  output logic o_charger_current_output
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [7:0] latch;
    logic [7:0] dir;
    logic [15:0] analog_enable_bit;
    logic [7:0] rdata;
    logic [7:0] pin_out;
    logic [7:0] pin_oe;
    logic [7:0] analog;
    logic pdly;
    logic ssel;
    logic charger;
  } pfm_state_s;

  pfm_state_s st_q;
  pfm_state_s st_d;

  logic [7:0] drv_out;
  logic [7:0] drv_oe;
  logic [7:0] level;
  logic pdly;

  // ==========================================================
  // pin drive and sense paths
  pfm_pin_drive u_drive (
    .i_latch(st_q.latch),
    .i_dir(st_q.dir),
    .i_cmp(i_cmp),
    .o_out(drv_out),
    .o_oe(drv_oe)
  );

  pfm_pin_sense u_sense (
    .i_pin_st(i_pin_st),
    .i_dir(st_q.dir),
    .i_analog_enable_bit(st_q.analog_enable_bit),
    .i_vref_out_en(i_cmp.vref_out_en),
    .o_level(level),
    .o_pdly(pdly)
  );

  // ==========================================================
  // next state
  always_comb begin
    st_d = st_q;
    st_d.rdata = RDATA_RST;
    if (i_bus.wr) begin
      case (i_bus.addr)
        OFS_PIN_LEVEL: begin
          st_d.latch = i_bus.wdata & IMPL_MASK;
        end
        OFS_OUT_LATCH: begin
          st_d.latch = i_bus.wdata & IMPL_MASK;
        end
        OFS_DIRECTION: begin
          st_d.dir = i_bus.wdata & IMPL_MASK;
        end
        OFS_ANALOG_ENABLE_BIT_LOW: begin
          st_d.analog_enable_bit[7:0] = i_bus.wdata;
        end
        OFS_ANALOG_ENABLE_BIT_HIGH: begin
          st_d.analog_enable_bit[15:8] = i_bus.wdata;
        end
        default: begin
          st_d.latch = st_q.latch;
        end
      endcase
    end
    if (i_bus.rd) begin
      case (i_bus.addr)
        OFS_PIN_LEVEL: begin
          st_d.rdata = level;
        end
        OFS_OUT_LATCH: begin
          st_d.rdata = st_q.latch & IMPL_MASK;
        end
        OFS_DIRECTION: begin
          st_d.rdata = st_q.dir & IMPL_MASK;
        end
        OFS_ANALOG_ENABLE_BIT_LOW: begin
          st_d.rdata = st_q.analog_enable_bit[7:0];
        end
        OFS_ANALOG_ENABLE_BIT_HIGH: begin
          st_d.rdata = st_q.analog_enable_bit[15:8];
        end
        default: begin
          st_d.rdata = RDATA_RST;
        end
      endcase
    end
    st_d.pin_out = drv_out;
    st_d.pin_oe = drv_oe;
    st_d.analog = pfm_analog_mask(st_q.analog_enable_bit);
    st_d.pdly = pdly;
    st_d.ssel = st_q.dir[PIN_SSEL] ? i_pin7_ttl : 1'b1;
    st_d.charger = i_cmp.charger_en;
  end

  // ==========================================================
  // registers
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      st_q.latch <= LATCH_RST;
      st_q.dir <= DIR_RST;
      st_q.analog_enable_bit <= ANALOG_ENABLE_BIT_RST;
      st_q.rdata <= RDATA_RST;
      st_q.pin_out <= 8'h00;
      st_q.pin_oe <= 8'h00;
      st_q.analog <= IMPL_MASK;
      st_q.pdly <= 1'b0;
      st_q.ssel <= 1'b1;
      st_q.charger <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // outputs
  assign o_rdata = st_q.rdata;
  assign o_pin_out = st_q.pin_out;
  assign o_pin_oe = st_q.pin_oe;
  assign o_analog_sel = st_q.analog;
  assign o_pulse_delay_input = st_q.pdly;
  assign o_serial_slave_select = st_q.ssel;
  assign o_charger_current_output = st_q.charger;

endmodule
